// >>> src/stp_pkg.sv
// Constants, register map and state codes for the segment receiver.
// Assumes one 20 MHz system clock shared by all users of this package.
package stp_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CHTYPE = 8'h04;
	localparam logic [7:0] REG_FRAME = 8'h08;
	localparam logic [7:0] REG_PKTGAP = 8'h0c;
	localparam logic [7:0] REG_CHGAP = 8'h10;
	localparam logic [7:0] REG_MBDROP = 8'h14;
	localparam logic [7:0] REG_SEGERR = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	localparam int CTRL_PKT_CHK = 0;
	localparam int CTRL_CH_CHK = 1;
	localparam int CTRL_WIN_DROP = 2;
	localparam logic [2:0] CTRL_RESET = 3'h7;
	localparam int CHT_OFDM_LSB = 0;
	localparam int CHT_PLC_LSB = 8;
	localparam int CHT_OFDM_EN = 16;
	localparam int CHT_PLC_EN = 17;
	localparam logic [17:0] CHTYPE_RESET = 18'h00100;
	localparam logic [31:0] FRAME_RESET = 32'h0000_1000;
	localparam logic [31:0] MIN_ADV = 32'h0000_0001;
	localparam logic [31:0] MAX_ADV = 32'h0000_0014;
	localparam logic [13:0] TS_BYTES = 14'h0004;
	localparam logic [13:0] CRC_BYTES = 14'h0003;
	localparam logic [13:0] LAST_BYTE = 14'h0001;
	localparam logic [1:0] TS_LAST = 2'h3;
	localparam logic [23:0] CRC_POLY = 24'h864cfb;
	localparam logic [23:0] CRC_INIT = 24'hffffff;
	localparam logic [2:0] UNTRACKED = 3'h0;
	localparam logic [3:0] PROF_ZERO = 4'h0;
	localparam logic [2:0] PROF_UPPER_ZERO = 3'h0;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [3:0] SEQ_ONE = 4'h1;
	localparam logic [15:0] PSEQ_ONE = 16'h0001;
	localparam logic [6:0] SEGS_ONE = 7'h01;
	localparam logic [1:0] TS_ONE = 2'h1;
	localparam logic [13:0] REM_ONE = 14'h0001;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TIME = 2'b01,
		ST_BODY = 2'b10,
		ST_DROP = 2'b11
	} stp_state_t;
	typedef enum logic [1:0] {
		CLS_SC = 2'b00,
		CLS_OFDM = 2'b01,
		CLS_PLC = 2'b10
	} stp_class_t;
endpackage

// >>> src/stp_seg_rx.sv
// Receive side of a segmented downstream tunnel: sequence checks, segment
// classification, timestamp strip and window check, CRC-24 insertion.
// Assumes headers and payload bytes come from logic on sys_clk_i.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module stp_seg_rx (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic [31:0] sys_time_i,
	input  wire logic        pkt_start_i,
	input  wire logic [2:0]  pkt_flow_i,
	input  wire logic        pkt_seq_ok_i,
	input  wire logic [15:0] pkt_seq_i,
	input  wire logic [6:0]  pkt_seg_count_i,
	input  wire logic        seg_hdr_valid_i,
	input  wire logic [7:0]  segment_channel_tag_i,
	input  wire logic [3:0]  seg_chan_seq_i,
	input  wire logic [3:0]  modulation_profile_field_i,
	input  wire logic        seg_begin_i,
	input  wire logic [13:0] seg_len_i,
	input  wire logic        in_valid_i,
	input  wire logic [7:0]  in_data_i,
	output logic             out_valid_o,
	output logic      [7:0]  out_data_o,
	output logic             out_first_o,
	output logic             out_last_o,
	output logic             out_mblock_o,
	output logic      [7:0]  out_tag_o,
	output logic      [2:0]  out_flow_o,
	output logic      [3:0]  out_profile_o,
	output logic             out_ts_valid_o,
	output logic      [31:0] out_time_o
);
	function automatic logic [23:0] crc24_byte(input logic [23:0] c, input logic [7:0] d);
		logic [23:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			if (r[23] ^ d[i])
				r = {r[22:0], 1'b0} ^ stp_pkg::CRC_POLY;
			else
				r = {r[22:0], 1'b0};
		end
		return r;
	endfunction

	logic [2:0]  ctrl;
	logic [17:0] chtype;
	logic [31:0] frame_ticks;
	logic [15:0] pkt_gap_cnt;
	logic [15:0] ch_gap_cnt;
	logic [15:0] mb_drop_cnt;
	logic [15:0] seg_err_cnt;
	logic [15:0] pseq_last [0:7];
	logic [7:0]  pseq_seen;
	logic [3:0]  chseq_mem [0:255];
	logic [255:0] chseq_seen;
	logic [7:0]  discard;
	logic [3:0]  prof_hold [0:7];
	logic [2:0]  cur_flow;
	logic [6:0]  segs_left;
	stp_pkg::stp_state_t state;
	stp_pkg::stp_class_t seg_cls;
	logic        seg_mb;
	logic        seg_first;
	logic [13:0] rem;
	logic [1:0]  ts_cnt;
	logic [23:0] ts_sh;
	logic [23:0] crc;

	// Header decode on the cycle each header is offered; window check on the last timestamp byte
	logic        hdr_take;
	logic        hdr_bad;
	logic        is_plc;
	logic        is_ofdm;
	logic        is_mb;
	logic        has_ts;
	logic [7:0]  ch_idx;
	logic        ch_gap;
	logic        pdu_drop;
	logic        mb_short;
	logic        pkt_gap;
	logic [31:0] ts_full;
	logic [31:0] ts_delta;
	logic        in_win;
	logic        ts_done;
	logic        mb_drop;
	logic [3:0]  next_prof;

	assign hdr_take = seg_hdr_valid_i && state == stp_pkg::ST_IDLE && segs_left != '0;
	assign hdr_bad = seg_hdr_valid_i && !hdr_take;
	assign is_plc = chtype[stp_pkg::CHT_PLC_EN]
		&& segment_channel_tag_i == chtype[stp_pkg::CHT_PLC_LSB +: 8];
	assign is_ofdm = !is_plc && chtype[stp_pkg::CHT_OFDM_EN]
		&& segment_channel_tag_i == chtype[stp_pkg::CHT_OFDM_LSB +: 8];
	assign is_mb = is_plc && modulation_profile_field_i[0];
	assign has_ts = is_mb && seg_begin_i;
	assign mb_short = is_mb && seg_len_i < (has_ts ? stp_pkg::TS_BYTES + stp_pkg::CRC_BYTES
		: stp_pkg::CRC_BYTES);
	// Only tags below 32 are tracked; larger session tags skip the loss check
	assign ch_idx = {cur_flow, segment_channel_tag_i[4:0]};
	assign ch_gap = ctrl[stp_pkg::CTRL_CH_CHK] && segment_channel_tag_i[7:5] == stp_pkg::UNTRACKED
		&& chseq_seen[ch_idx] && seg_chan_seq_i != chseq_mem[ch_idx] + stp_pkg::SEQ_ONE;
	assign pdu_drop = !is_mb && !seg_begin_i && (ch_gap || discard[cur_flow]);
	assign pkt_gap = pkt_start_i && pkt_seq_ok_i && ctrl[stp_pkg::CTRL_PKT_CHK]
		&& pseq_seen[pkt_flow_i]
		&& pkt_seq_i != pseq_last[pkt_flow_i] + stp_pkg::PSEQ_ONE;
	assign ts_full = {ts_sh, in_data_i};
	assign ts_delta = ts_full - sys_time_i;
	assign in_win = ts_delta >= 32'(frame_ticks * stp_pkg::MIN_ADV)
		&& ts_delta <= 32'(frame_ticks * stp_pkg::MAX_ADV);
	assign ts_done = state == stp_pkg::ST_TIME && in_valid_i && ts_cnt == stp_pkg::TS_LAST;
	assign mb_drop = ts_done && ctrl[stp_pkg::CTRL_WIN_DROP] && !in_win;

	always_comb
	begin
		if (is_plc)
			next_prof = {stp_pkg::PROF_UPPER_ZERO, modulation_profile_field_i[0]};
		else if (is_ofdm)
			next_prof = seg_begin_i ? modulation_profile_field_i : prof_hold[cur_flow];
		else
			next_prof = stp_pkg::PROF_ZERO;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl <= stp_pkg::CTRL_RESET;
			chtype <= stp_pkg::CHTYPE_RESET;
			frame_ticks <= stp_pkg::FRAME_RESET;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == stp_pkg::REG_CTRL)
				ctrl <= reg_wdata_i[2:0];
			else if (reg_addr_i == stp_pkg::REG_CHTYPE)
				chtype <= reg_wdata_i[17:0];
			else if (reg_addr_i == stp_pkg::REG_FRAME)
				frame_ticks <= reg_wdata_i;
		end
	end

	// Read data stands only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= '0;
		else if (!reg_rd_i)
			reg_rdata_o <= '0;
		else if (reg_addr_i == stp_pkg::REG_CTRL)
			reg_rdata_o <= {29'h0, ctrl};
		else if (reg_addr_i == stp_pkg::REG_CHTYPE)
			reg_rdata_o <= {14'h0, chtype};
		else if (reg_addr_i == stp_pkg::REG_FRAME)
			reg_rdata_o <= frame_ticks;
		else if (reg_addr_i == stp_pkg::REG_PKTGAP)
			reg_rdata_o <= {16'h0, pkt_gap_cnt};
		else if (reg_addr_i == stp_pkg::REG_CHGAP)
			reg_rdata_o <= {16'h0, ch_gap_cnt};
		else if (reg_addr_i == stp_pkg::REG_MBDROP)
			reg_rdata_o <= {16'h0, mb_drop_cnt};
		else if (reg_addr_i == stp_pkg::REG_SEGERR)
			reg_rdata_o <= {16'h0, seg_err_cnt};
		else if (reg_addr_i == stp_pkg::REG_STATUS)
			reg_rdata_o <= {16'h0, discard, 1'b0, segs_left};
		else
			reg_rdata_o <= '0;
	end

	// Packet level: flow, segment budget, sequence tracking
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pseq_seen <= '0;
			pkt_gap_cnt <= '0;
			cur_flow <= '0;
			segs_left <= '0;
			for (int i = 0; i < 8; i++)
				pseq_last[i] <= '0;
		end
		else
		begin
			if (pkt_start_i)
			begin
				cur_flow <= pkt_flow_i;
				segs_left <= pkt_seg_count_i;
				if (pkt_seq_ok_i)
				begin
					pseq_last[pkt_flow_i] <= pkt_seq_i;
					pseq_seen[pkt_flow_i] <= 1'b1;
				end
			end
			else if (hdr_take)
				segs_left <= segs_left - stp_pkg::SEGS_ONE;
			if (pkt_gap)
				pkt_gap_cnt <= pkt_gap_cnt + stp_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			seg_err_cnt <= '0;
		else if (hdr_bad || (hdr_take && mb_short))
			seg_err_cnt <= seg_err_cnt + stp_pkg::CNT_ONE;
	end

	// Channel level: sequence memory, loss count, PDU resynchronisation
	always_ff @(posedge sys_clk_i)
	begin
		// Untracked tags alias tracked slots, so they must not touch the history
		if (hdr_take && segment_channel_tag_i[7:5] == stp_pkg::UNTRACKED)
			chseq_mem[ch_idx] <= seg_chan_seq_i;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			chseq_seen <= '0;
			ch_gap_cnt <= '0;
			discard <= '0;
			for (int i = 0; i < 8; i++)
				prof_hold[i] <= '0;
		end
		else if (hdr_take)
		begin
			if (segment_channel_tag_i[7:5] == stp_pkg::UNTRACKED)
				chseq_seen[ch_idx] <= 1'b1;
			if (ch_gap)
				ch_gap_cnt <= ch_gap_cnt + stp_pkg::CNT_ONE;
			if (!is_mb && seg_begin_i)
				discard[cur_flow] <= 1'b0;
			else if (!is_mb && ch_gap)
				discard[cur_flow] <= 1'b1;
			if (is_ofdm && seg_begin_i)
				prof_hold[cur_flow] <= modulation_profile_field_i;
		end
	end

	// Segment walker; bytes pass straight through so arrival order is kept
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= stp_pkg::ST_IDLE;
			seg_cls <= stp_pkg::CLS_SC;
			seg_mb <= 1'b0;
			seg_first <= 1'b0;
			rem <= '0;
			ts_cnt <= '0;
			ts_sh <= '0;
			crc <= stp_pkg::CRC_INIT;
			out_tag_o <= '0;
			out_flow_o <= '0;
			out_profile_o <= '0;
			out_ts_valid_o <= 1'b0;
			out_time_o <= '0;
		end
		else
		begin
			case (state)
				stp_pkg::ST_IDLE:
					if (hdr_take)
					begin
						seg_cls <= is_plc ? stp_pkg::CLS_PLC
							: (is_ofdm ? stp_pkg::CLS_OFDM : stp_pkg::CLS_SC);
						seg_mb <= is_mb;
						seg_first <= 1'b1;
						rem <= seg_len_i;
						ts_cnt <= '0;
						crc <= stp_pkg::CRC_INIT;
						out_tag_o <= segment_channel_tag_i;
						out_flow_o <= cur_flow;
						out_profile_o <= next_prof;
						out_ts_valid_o <= 1'b0;
						if (seg_len_i == '0)
							state <= stp_pkg::ST_IDLE;
						else if (pdu_drop || mb_short)
							state <= stp_pkg::ST_DROP;
						else if (has_ts)
							state <= stp_pkg::ST_TIME;
						else
							state <= stp_pkg::ST_BODY;
					end
				stp_pkg::ST_TIME:
					if (in_valid_i)
					begin
						rem <= rem - stp_pkg::REM_ONE;
						ts_cnt <= ts_cnt + stp_pkg::TS_ONE;
						ts_sh <= ts_full[23:0];
						if (ts_done)
						begin
							// Time leaves with the block so local logic can build the stamp block
							out_time_o <= ts_full;
							out_ts_valid_o <= 1'b1;
							state <= mb_drop ? stp_pkg::ST_DROP : stp_pkg::ST_BODY;
						end
					end
				stp_pkg::ST_BODY:
					if (in_valid_i)
					begin
						rem <= rem - stp_pkg::REM_ONE;
						seg_first <= 1'b0;
						if (seg_mb && rem > stp_pkg::CRC_BYTES)
							crc <= crc24_byte(crc, in_data_i);
						if (rem == stp_pkg::LAST_BYTE)
							state <= stp_pkg::ST_IDLE;
					end
				default:
					if (in_valid_i)
					begin
						rem <= rem - stp_pkg::REM_ONE;
						if (rem == stp_pkg::LAST_BYTE)
							state <= stp_pkg::ST_IDLE;
					end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mb_drop_cnt <= '0;
		else if (mb_drop)
			mb_drop_cnt <= mb_drop_cnt + stp_pkg::CNT_ONE;
	end

	// Output byte stage; the headend leaves the CRC slot blank, so it is overwritten
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
			out_first_o <= 1'b0;
			out_last_o <= 1'b0;
			out_mblock_o <= 1'b0;
		end
		else
		begin
			out_valid_o <= state == stp_pkg::ST_BODY && in_valid_i;
			out_first_o <= seg_first;
			out_last_o <= rem == stp_pkg::LAST_BYTE;
			out_mblock_o <= seg_mb;
			if (seg_mb && rem == stp_pkg::CRC_BYTES)
				out_data_o <= crc[23:16];
			else if (seg_mb && rem == stp_pkg::CRC_BYTES - stp_pkg::REM_ONE)
				out_data_o <= crc[15:8];
			else if (seg_mb && rem == stp_pkg::LAST_BYTE)
				out_data_o <= crc[7:0];
			else
				out_data_o <= in_data_i;
		end
	end

	a_sc_profile_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		out_valid_o && seg_cls == stp_pkg::CLS_SC |-> out_profile_o == stp_pkg::PROF_ZERO)
		else $error("single carrier profile not zero");
	a_plc_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		out_valid_o && seg_cls == stp_pkg::CLS_PLC
		|-> out_profile_o[3:1] == stp_pkg::PROF_UPPER_ZERO && out_profile_o[0] == out_mblock_o)
		else $error("phy link profile bits wrong");
	a_ts_needs_both: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		hdr_take && !(is_mb && seg_begin_i) |=> state != stp_pkg::ST_TIME)
		else $error("timestamp expected without type and begin");
	a_chan_gap_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		hdr_take && ch_gap |=> ch_gap_cnt == $past(ch_gap_cnt) + stp_pkg::CNT_ONE)
		else $error("channel gap not counted");
	a_pkt_gap_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pkt_gap |=> pkt_gap_cnt == $past(pkt_gap_cnt) + stp_pkg::CNT_ONE)
		else $error("packet gap not counted");
	a_window_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		mb_drop |=> state == stp_pkg::ST_DROP && !out_valid_o ##1 !out_valid_o)
		else $error("late or early block not dropped");
	a_pdu_resync: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		hdr_take && pdu_drop && seg_len_i != '0 |=> state == stp_pkg::ST_DROP && discard[cur_flow])
		else $error("segment after gap not discarded");
	a_crc_insert: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		state == stp_pkg::ST_BODY && in_valid_i && seg_mb && rem == stp_pkg::CRC_BYTES
		|=> out_valid_o && out_data_o == $past(crc[23:16]))
		else $error("crc byte not inserted");
endmodule

// >>> tb/stp_headend_model.sv
// Headend side model: packet headers, segment table entries, payload bytes.
// Assumes the receiver takes one header or one byte per sys_clk_i edge.
`timescale 1ns/1ps
module stp_headend_model #(
	parameter logic [15:0] SEQ_START = 16'h5a3c // Arbitrary start value
) (
	input  wire logic  sys_clk_i,
	output logic       pkt_start_o,
	output logic [2:0] pkt_flow_o,
	output logic [15:0] pkt_seq_o,
	output logic [6:0] pkt_seg_count_o,
	output logic       seg_hdr_valid_o,
	output logic [7:0] segment_channel_tag_o,
	output logic [3:0] seg_chan_seq_o,
	output logic [3:0] modulation_profile_field_o,
	output logic       seg_begin_o,
	output logic [13:0] seg_len_o,
	output logic       in_valid_o,
	output logic [7:0] in_data_o
);
	logic [15:0] pseq [8];
	logic [3:0]  cseq [8][256];
	initial
	begin
		{pkt_start_o, pkt_flow_o, pkt_seq_o, pkt_seg_count_o, seg_hdr_valid_o} = '0;
		{segment_channel_tag_o, seg_chan_seq_o, modulation_profile_field_o} = '0;
		{seg_begin_o, seg_len_o, in_valid_o, in_data_o} = '0;
		foreach (pseq[f]) pseq[f] = SEQ_START;
		foreach (cseq[f, c]) cseq[f][c] = 4'h0;
	end
	// Skip only on command, to provoke a gap at the receiver
	task automatic send_pkt(input logic [2:0] fl, input logic [6:0] cnt, input bit skip);
		@(posedge sys_clk_i);
		pkt_start_o <= 1'b1;
		pkt_flow_o <= fl;
		pkt_seq_o <= pseq[fl] + (skip ? 16'h0001 : 16'h0000);
		pkt_seg_count_o <= cnt;
		pseq[fl] = pseq[fl] + (skip ? 16'h0002 : 16'h0001);
		@(posedge sys_clk_i);
		pkt_start_o <= 1'b0;
		pkt_seq_o <= ~pkt_seq_o;
	endtask
	task automatic send_seg(input logic [2:0] fl, input logic [7:0] tg, input logic [3:0] pf,
		input bit beg, input int n, input logic [7:0] base, input bit stamp,
		input logic [31:0] ts, input bit skip);
		int len;
		len = n + (stamp ? 4 : 0);
		cseq[fl][tg] = cseq[fl][tg] + (skip ? 4'h2 : 4'h1);
		@(posedge sys_clk_i);
		seg_hdr_valid_o <= 1'b1;
		segment_channel_tag_o <= tg;
		seg_chan_seq_o <= cseq[fl][tg];
		modulation_profile_field_o <= pf;
		seg_begin_o <= beg;
		seg_len_o <= 14'(len);
		@(posedge sys_clk_i);
		seg_hdr_valid_o <= 1'b0;
		segment_channel_tag_o <= ~tg;
		for (int i = 0; i < len; i++)
		begin
			in_valid_o <= 1'b1;
			// Timestamp goes out big-endian ahead of the block
			in_data_o <= (stamp && i < 4) ? ts[31 - 8 * i -: 8] : base + 8'(i - len + n);
			@(posedge sys_clk_i);
		end
		in_valid_o <= 1'b0;
		in_data_o <= ~in_data_o;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the segment receiver.
// Assumes the headend model drives the header and payload inputs except pkt_seq_ok_i.
`timescale 1ns/1ps
module testbench;
	logic        sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, sys_time_i, out_time_o;
	logic        pkt_start_i, seg_hdr_valid_i, seg_begin_i, in_valid_i;
	logic        pkt_seq_ok_i;
	logic [2:0]  pkt_flow_i, out_flow_o;
	logic [15:0] pkt_seq_i;
	logic [6:0]  pkt_seg_count_i;
	logic [7:0]  segment_channel_tag_i, in_data_i, out_data_o, out_tag_o;
	logic [3:0]  seg_chan_seq_i, modulation_profile_field_i, out_profile_o;
	logic [13:0] seg_len_i;
	logic        out_valid_o, out_first_o, out_last_o, out_mblock_o, out_ts_valid_o;
	int          n_errors = 0;
	int          n_checks = 0;
	logic [26:0] q [$];
	logic [31:0] tq [$];
	stp_seg_rx i_dut (.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .sys_time_i, .pkt_start_i, .pkt_flow_i,
		.pkt_seq_ok_i, .pkt_seq_i, .pkt_seg_count_i, .seg_hdr_valid_i,
		.segment_channel_tag_i, .seg_chan_seq_i, .modulation_profile_field_i, .seg_begin_i,
		.seg_len_i, .in_valid_i, .in_data_i, .out_valid_o, .out_data_o, .out_first_o,
		.out_last_o, .out_mblock_o, .out_tag_o, .out_flow_o, .out_profile_o,
		.out_ts_valid_o, .out_time_o);
	stp_headend_model i_hc (.sys_clk_i, .pkt_start_o(pkt_start_i), .pkt_flow_o(pkt_flow_i),
		.pkt_seq_o(pkt_seq_i), .pkt_seg_count_o(pkt_seg_count_i),
		.seg_hdr_valid_o(seg_hdr_valid_i), .segment_channel_tag_o(segment_channel_tag_i),
		.seg_chan_seq_o(seg_chan_seq_i), .modulation_profile_field_o(modulation_profile_field_i),
		.seg_begin_o(seg_begin_i), .seg_len_o(seg_len_i), .in_valid_o(in_valid_i),
		.in_data_o(in_data_i));
	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i)
		sys_time_i <= sys_time_i + 32'h1;
	always @(posedge sys_clk_i)
		if (out_valid_o === 1'b1)
		begin
			q.push_back({out_flow_o, out_ts_valid_o, out_mblock_o, out_first_o, out_last_o,
				out_profile_o, out_tag_o, out_data_o});
			tq.push_back(out_time_o);
		end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask
	function automatic logic [23:0] crc24(input logic [23:0] c, input logic [7:0] d);
		c = c ^ {d, 16'h0000};
		for (int j = 0; j < 8; j++)
			c = c[23] ? ((c << 1) ^ stp_pkg::CRC_POLY) : (c << 1);
		return c;
	endfunction
	// Expected bytes follow the model's pattern; a block's last three become its CRC
	task automatic chk_seg(input int n, input logic [2:0] fl, input logic [7:0] tg,
		input logic [3:0] pf, input bit mb, input bit tsv, input logic [31:0] ts,
		input logic [7:0] base);
		logic [23:0] crc;
		logic [7:0]  d;
		logic [26:0] e, g;
		int          k;
		k = 0;
		while (q.size() < n && k < 300)
		begin
			@(posedge sys_clk_i);
			k++;
		end
		crc = stp_pkg::CRC_INIT;
		for (int i = 0; i < n; i++)
		begin
			d = base + 8'(i);
			if (mb && i >= n - 3)
				d = crc[23 - 8 * (i - n + 3) -: 8];
			else if (mb)
				crc = crc24(crc, d);
			e = {fl, tsv, mb, i == 0, i == n - 1, pf, tg, d};
			g = (q.size() > 0) ? q.pop_front() : 'x;
			// Stamp flag is only judged on the first byte
			if (i > 0)
				e[23] = g[23];
			chk(32'(g), 32'(e));
			if (i == 0 && tsv)
				chk(tq[0], ts);
			if (tq.size() > 0)
				void'(tq.pop_front());
		end
	endtask
	task automatic s_regs();
		reg_chk(stp_pkg::REG_CTRL, 32'h7);
		reg_chk(stp_pkg::REG_CHTYPE, 32'h100);
		reg_chk(stp_pkg::REG_FRAME, 32'h1000);
		reg_wr(stp_pkg::REG_PKTGAP, 32'h5);
		reg_chk(stp_pkg::REG_PKTGAP, 32'h0);
		reg_chk(8'h20, 32'h0);
		reg_wr(stp_pkg::REG_CHTYPE, 32'h0003_0100);
		reg_chk(stp_pkg::REG_CHTYPE, 32'h0003_0100);
		reg_wr(stp_pkg::REG_FRAME, 32'h40);
		reg_chk(stp_pkg::REG_FRAME, 32'h40);
	endtask
	task automatic s_classes();
		i_hc.send_pkt(3'h0, 7'h1, 1'b0);
		i_hc.send_seg(3'h0, 8'h05, 4'ha, 1'b1, 4, 8'h10, 1'b0, 32'h0, 1'b0);
		chk_seg(4, 3'h0, 8'h05, 4'h0, 1'b0, 1'b0, 32'h0, 8'h10);
		i_hc.send_pkt(3'h1, 7'h2, 1'b0);
		i_hc.send_seg(3'h1, 8'h00, 4'h3, 1'b1, 3, 8'h20, 1'b0, 32'h0, 1'b0);
		i_hc.send_seg(3'h1, 8'h00, 4'h0, 1'b0, 2, 8'h30, 1'b0, 32'h0, 1'b0);
		chk_seg(3, 3'h1, 8'h00, 4'h3, 1'b0, 1'b0, 32'h0, 8'h20);
		chk_seg(2, 3'h1, 8'h00, 4'h3, 1'b0, 1'b0, 32'h0, 8'h30);
		i_hc.send_pkt(3'h0, 7'h2, 1'b0);
		i_hc.send_seg(3'h0, 8'h01, 4'h1, 1'b0, 6, 8'h50, 1'b0, 32'h0, 1'b0);
		i_hc.send_seg(3'h0, 8'h01, 4'h0, 1'b1, 3, 8'h58, 1'b0, 32'h0, 1'b0);
		chk_seg(6, 3'h0, 8'h01, 4'h1, 1'b1, 1'b0, 32'h0, 8'h50);
		chk_seg(3, 3'h0, 8'h01, 4'h0, 1'b0, 1'b0, 32'h0, 8'h58);
	endtask
	task automatic s_stamps();
		logic [31:0] t;
		t = sys_time_i;
		i_hc.send_pkt(3'h0, 7'h4, 1'b0);
		i_hc.send_seg(3'h0, 8'h01, 4'h1, 1'b1, 5, 8'h40, 1'b1, t + 32'd320, 1'b0);
		i_hc.send_seg(3'h0, 8'h01, 4'h1, 1'b1, 5, 8'h60, 1'b1, t + 32'd320, 1'b0);
		i_hc.send_seg(3'h0, 8'h01, 4'h1, 1'b1, 5, 8'h70, 1'b1, t + 32'd1600, 1'b0);
		i_hc.send_seg(3'h0, 8'h01, 4'h1, 1'b1, 5, 8'h78, 1'b1, t + 32'd8, 1'b0);
		chk_seg(5, 3'h0, 8'h01, 4'h1, 1'b1, 1'b1, t + 32'd320, 8'h40);
		chk_seg(5, 3'h0, 8'h01, 4'h1, 1'b1, 1'b1, t + 32'd320, 8'h60);
		chk(32'(q.size()), 32'h0);
		reg_chk(stp_pkg::REG_MBDROP, 32'h2);
	endtask
	task automatic s_gaps();
		i_hc.send_pkt(3'h2, 7'h4, 1'b0);
		i_hc.send_seg(3'h2, 8'h05, 4'h0, 1'b1, 2, 8'h80, 1'b0, 32'h0, 1'b0);
		i_hc.send_seg(3'h2, 8'h05, 4'h0, 1'b0, 2, 8'h88, 1'b0, 32'h0, 1'b1);
		i_hc.send_seg(3'h2, 8'h05, 4'h0, 1'b0, 2, 8'h90, 1'b0, 32'h0, 1'b0);
		chk_seg(2, 3'h2, 8'h05, 4'h0, 1'b0, 1'b0, 32'h0, 8'h80);
		chk(32'(q.size()), 32'h0);
		reg_chk(stp_pkg::REG_CHGAP, 32'h1);
		i_hc.send_seg(3'h2, 8'h05, 4'h0, 1'b1, 2, 8'h98, 1'b0, 32'h0, 1'b0);
		chk_seg(2, 3'h2, 8'h05, 4'h0, 1'b0, 1'b0, 32'h0, 8'h98);
		reg_chk(stp_pkg::REG_PKTGAP, 32'h0);
		i_hc.send_pkt(3'h2, 7'h0, 1'b1);
		reg_chk(stp_pkg::REG_PKTGAP, 32'h1);
		// An invalid sequence field must not be judged
		pkt_seq_ok_i <= 1'b0;
		i_hc.send_pkt(3'h2, 7'h0, 1'b1);
		reg_chk(stp_pkg::REG_PKTGAP, 32'h1);
		pkt_seq_ok_i <= 1'b1;
		// With the packet check switched off a gap is not counted
		reg_wr(stp_pkg::REG_CTRL, 32'h6);
		i_hc.send_pkt(3'h2, 7'h0, 1'b1);
		reg_chk(stp_pkg::REG_PKTGAP, 32'h1);
		reg_wr(stp_pkg::REG_CTRL, 32'h7);
		reg_chk(stp_pkg::REG_CTRL, 32'h7);
	endtask
	task automatic s_count();
		i_hc.send_pkt(3'h3, 7'h2, 1'b0);
		i_hc.send_seg(3'h3, 8'h06, 4'h0, 1'b1, 2, 8'ha0, 1'b0, 32'h0, 1'b0);
		reg_chk(stp_pkg::REG_STATUS, 32'h1);
		i_hc.send_seg(3'h3, 8'h06, 4'h0, 1'b0, 2, 8'ha8, 1'b0, 32'h0, 1'b0);
		i_hc.send_seg(3'h3, 8'h06, 4'h0, 1'b0, 2, 8'hb0, 1'b0, 32'h0, 1'b0);
		chk_seg(2, 3'h3, 8'h06, 4'h0, 1'b0, 1'b0, 32'h0, 8'ha0);
		chk_seg(2, 3'h3, 8'h06, 4'h0, 1'b0, 1'b0, 32'h0, 8'ha8);
		chk(32'(q.size()), 32'h0);
		reg_chk(stp_pkg::REG_SEGERR, 32'h1);
	endtask
	task automatic final_report();
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		// Whole run is well under a thousand cycles
		repeat (5000) @(posedge sys_clk_i);
		n_errors++;
		final_report();
	end
	initial
	begin
		{rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, sys_time_i} = '0;
		pkt_seq_ok_i = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		s_regs();
		s_classes();
		s_stamps();
		s_gaps();
		s_count();
		repeat (4) @(posedge sys_clk_i);
		final_report();
	end
endmodule
